/* src/audio_port_irq_pkg.sv */
// constants, field layouts and carrier types for the audio port interrupt and timing block
//
// Functional notes
// - Raw status holds one sticky bit per source, set regardless of enables.
// - Masked status shows raw bits only where the enable bit is set.
// - Read-write enable register selects which sources reach masked status and irq.
// - Writing one to a clear bit clears that raw bit and its masked bit.
// - Optional inversion of incoming transmit bit clock when transmitter is clock slave.
// - Data-valid flag is delayed by the programmed data-enable delay count.
// - Optional extra two-stage synchroniser on the receiver's incoming serial signals.
// - Optional extra two-stage synchroniser on the transmitter's incoming serial signals.
// - Each outgoing serial signal is delayed by its own programmed cycle count.
// - Each incoming serial signal is delayed by its own programmed cycle count.
// - Received words are counted against receive length; reaching it raises frame-complete.
// - Constant-output channel modes drive the constant value on the chosen channel.
// - Frame-complete interrupt is set once all expected receive data arrived.
// - Receive-done interrupt is set each time the DMA finishes a descriptor.
package audio_port_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_RAW_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASKED_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE        = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR         = 8'h18;
  localparam logic [7:0] OFS_TIMING_CONTROL    = 8'h1c;
  localparam logic [7:0] OFS_RECEIVE_LENGTH    = 8'h24;
  localparam logic [7:0] OFS_CONSTANT_VALUE    = 8'h28;

  // ----------------------------------------------------------------
  // interrupt source bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_COUNT                   = 16;
  localparam int IRQ_RX_TAKE_DATA            = 0;
  localparam int IRQ_TX_REFILL_REQUEST       = 1;
  localparam int IRQ_RX_FIFO_FILLED          = 2;
  localparam int IRQ_RX_FIFO_DRAINED         = 3;
  localparam int IRQ_TX_FIFO_FILLED          = 4;
  localparam int IRQ_TX_FIFO_DRAINED         = 5;
  localparam int IRQ_RX_HANG                 = 6;
  localparam int IRQ_TX_HANG                 = 7;
  localparam int IRQ_RX_DONE                 = 8;
  localparam int IRQ_RX_FRAME_COMPLETE       = 9;
  localparam int IRQ_TX_DONE                 = 10;
  localparam int IRQ_TX_EOF                  = 11;
  localparam int IRQ_RX_DESCRIPTOR_FAULT     = 12;
  localparam int IRQ_TX_DESCRIPTOR_FAULT     = 13;
  localparam int IRQ_RX_DESCRIPTOR_EXHAUSTED = 14;
  localparam int IRQ_TX_TOTAL_EOF            = 15;

  localparam logic [15:0] IRQ_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // serial pin indices (incoming and outgoing vectors)
  // ----------------------------------------------------------------
  localparam int PIN_COUNT      = 5;
  localparam int PIN_RX_DATA    = 0;
  localparam int PIN_RX_WORDSEL = 1;
  localparam int PIN_RX_BITCLK  = 2;
  localparam int PIN_TX_WORDSEL = 3;
  localparam int PIN_TX_BITCLK  = 4;
  localparam logic [4:0] PIN_IS_RX = 5'h07;

  localparam int OUT_RX_BITCLK  = 0;
  localparam int OUT_RX_WORDSEL = 1;
  localparam int OUT_TX_DATA    = 2;
  localparam int OUT_TX_WORDSEL = 3;
  localparam int OUT_TX_BITCLK  = 4;

  localparam int DELAY_W    = 2;
  localparam int HIST_DEPTH = 4;

  // ----------------------------------------------------------------
  // transmit channel arrangements with a constant channel
  // ----------------------------------------------------------------
  localparam logic [2:0] CHAN_CONST_RIGHT = 3'h3;
  localparam logic [2:0] CHAN_CONST_LEFT  = 3'h4;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               tx_bitclk_input_invert;
    logic [DELAY_W-1:0] data_enable_delay;
    logic               tx_two_stage_sync;
    logic               rx_two_stage_sync;
    logic [DELAY_W-1:0] rx_bitclk_output_delay;
    logic [DELAY_W-1:0] rx_wordsel_output_delay;
    logic [DELAY_W-1:0] tx_serdata_output_delay;
    logic [DELAY_W-1:0] tx_wordsel_output_delay;
    logic [DELAY_W-1:0] tx_bitclk_output_delay;
    logic [DELAY_W-1:0] rx_serdata_input_delay;
    logic [DELAY_W-1:0] rx_wordsel_input_delay;
    logic [DELAY_W-1:0] rx_bitclk_input_delay;
    logic [DELAY_W-1:0] tx_wordsel_input_delay;
    logic [DELAY_W-1:0] tx_bitclk_input_delay;
  } timing_type;

  localparam int TIMING_W = $bits(timing_type);

  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } sample_pair_type;

  typedef struct packed {
    logic [15:0]                          raw;
    logic [15:0]                          ena;
    timing_type                           timing;
    logic [31:0]                          rx_len;
    logic [31:0]                          const_val;
    logic [31:0]                          rx_count;
    logic [31:0]                          rdata;
    logic [PIN_COUNT-1:0]                 s1;
    logic [PIN_COUNT-1:0]                 s2;
    logic [PIN_COUNT-1:0]                 d1;
    logic [PIN_COUNT-1:0]                 d2;
    logic [PIN_COUNT-1:0][HIST_DEPTH-1:0] ihist;
    logic [PIN_COUNT-1:0][HIST_DEPTH-1:0] ohist;
    logic [HIST_DEPTH-1:0]                dv_hist;
    logic                                 rx_bitclk_prev;
    sample_pair_type                      tx_data;
  } state_type;

endpackage : audio_port_irq_pkg

/* src/audio_port_irq_timing_regs.sv */
// interrupt registers, serial signal timing and constant channel logic of the audio port
`timescale 1ns/10ps
`default_nettype none

module audio_port_irq_timing_regs
  import audio_port_irq_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  output logic                      irq,
  input  wire logic [15:0]          irq_events,
  input  wire logic                 rx_word_strobe,
  input  wire logic                 data_valid_in,
  output logic                      data_valid_out,
  input  wire logic                 tx_slave_mode,
  input  wire logic [PIN_COUNT-1:0] pins_in,
  output logic      [PIN_COUNT-1:0] pins_out,
  output logic      [PIN_COUNT-1:0] link_in,
  input  wire logic [PIN_COUNT-1:0] link_out,
  output logic                      rx_bitclk_rise,
  input  wire logic [2:0]           tx_channel_arrangement,
  input  wire logic                 tx_msb_right,
  input  wire sample_pair_type      tx_sample,
  output var sample_pair_type       tx_channel_data
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // pick a tap of a delay line; tap 0 is the first flop
  function automatic logic tap(input logic [HIST_DEPTH-1:0] h, input logic [DELAY_W-1:0] n);
    return h[n];
  endfunction : tap

  // programmed delay of one incoming signal
  function automatic logic [DELAY_W-1:0] in_delay(input timing_type t, input int i);
    case (i)
      PIN_RX_DATA:    return t.rx_serdata_input_delay;
      PIN_RX_WORDSEL: return t.rx_wordsel_input_delay;
      PIN_RX_BITCLK:  return t.rx_bitclk_input_delay;
      PIN_TX_WORDSEL: return t.tx_wordsel_input_delay;
      default:        return t.tx_bitclk_input_delay;
    endcase
  endfunction : in_delay

  // programmed delay of one outgoing signal
  function automatic logic [DELAY_W-1:0] out_delay(input timing_type t, input int i);
    case (i)
      OUT_RX_BITCLK:  return t.rx_bitclk_output_delay;
      OUT_RX_WORDSEL: return t.rx_wordsel_output_delay;
      OUT_TX_DATA:    return t.tx_serdata_output_delay;
      OUT_TX_WORDSEL: return t.tx_wordsel_output_delay;
      default:        return t.tx_bitclk_output_delay;
    endcase
  endfunction : out_delay

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_type   st_reg;
  state_type   st_next;
  logic [15:0] clr;
  logic [15:0] ev;
  logic        sel;
  logic        sync_on;

  // next-state logic: bus, interrupts, counting and pin paths
  always_comb begin
    st_next = st_reg;
    clr     = '0;
    sel     = 1'b0;
    sync_on = 1'b0;
    // frame-complete is owned here, not by the outside event vector
    ev = irq_events;
    ev[IRQ_RX_FRAME_COMPLETE] = 1'b0;

    // register writes
    if (reg_write) begin
      case (reg_addr)
        OFS_IRQ_ENABLE:     st_next.ena = reg_wdata[15:0];
        OFS_IRQ_CLEAR:      clr = reg_wdata[15:0];
        OFS_TIMING_CONTROL: st_next.timing = timing_type'(reg_wdata[TIMING_W-1:0]);
        OFS_RECEIVE_LENGTH: begin
          st_next.rx_len   = reg_wdata;
          st_next.rx_count = '0;
        end
        OFS_CONSTANT_VALUE: st_next.const_val = reg_wdata;
        default: ;
      endcase
    end

    // receive length counter; a length of zero disables it
    if (rx_word_strobe && st_reg.rx_len != '0 &&
        !(reg_write && reg_addr == OFS_RECEIVE_LENGTH)) begin
      if (st_reg.rx_count + 32'h1 >= st_reg.rx_len) begin
        st_next.rx_count = '0;
        ev[IRQ_RX_FRAME_COMPLETE] = 1'b1;
      end else begin
        st_next.rx_count = st_reg.rx_count + 32'h1;
      end
    end

    // sticky raw bits; a new event beats a clear in the same cycle
    st_next.raw = (st_reg.raw & ~clr) | ev;

    // read data stands for one cycle only
    st_next.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        OFS_IRQ_RAW_STATUS:    st_next.rdata = {16'h0000, st_reg.raw};
        OFS_IRQ_MASKED_STATUS: st_next.rdata = {16'h0000, st_reg.raw & st_reg.ena};
        OFS_IRQ_ENABLE:        st_next.rdata = {16'h0000, st_reg.ena};
        OFS_TIMING_CONTROL:    st_next.rdata = 32'(st_reg.timing);
        OFS_RECEIVE_LENGTH:    st_next.rdata = st_reg.rx_len;
        OFS_CONSTANT_VALUE:    st_next.rdata = st_reg.const_val;
        default:               st_next.rdata = '0;
      endcase
    end

    // mandatory pin synchroniser, then the optional second pair
    st_next.s1 = pins_in;
    st_next.s2 = st_reg.s1;
    st_next.d1 = st_reg.s2;
    st_next.d2 = st_reg.d1;

    // incoming paths: optional extra sync, bclk inversion, delay line
    for (int i = 0; i < PIN_COUNT; i++) begin
      sync_on = PIN_IS_RX[i] ? st_reg.timing.rx_two_stage_sync
                             : st_reg.timing.tx_two_stage_sync;
      sel = sync_on ? st_reg.d2[i] : st_reg.s2[i];
      if (i == PIN_TX_BITCLK && tx_slave_mode && st_reg.timing.tx_bitclk_input_invert) begin
        sel = ~sel;
      end
      st_next.ihist[i] = {st_reg.ihist[i][HIST_DEPTH-2:0], sel};
      st_next.ohist[i] = {st_reg.ohist[i][HIST_DEPTH-2:0], link_out[i]};
    end

    st_next.dv_hist = {st_reg.dv_hist[HIST_DEPTH-2:0], data_valid_in};
    st_next.rx_bitclk_prev = tap(st_reg.ihist[PIN_RX_BITCLK],
                                 in_delay(st_reg.timing, PIN_RX_BITCLK));

    // channel data; constant modes replace one side with the constant
    st_next.tx_data = tx_sample;
    case (tx_channel_arrangement)
      CHAN_CONST_RIGHT: begin
        if (tx_msb_right) st_next.tx_data.left = st_reg.const_val;
        else              st_next.tx_data.right = st_reg.const_val;
      end
      CHAN_CONST_LEFT: begin
        if (tx_msb_right) st_next.tx_data.right = st_reg.const_val;
        else              st_next.tx_data.left = st_reg.const_val;
      end
      default: ;
    endcase
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg     <= '0;
      st_reg.raw <= IRQ_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // delay taps come straight off flops, so no glitching on the pins
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      link_in[i]  = tap(st_reg.ihist[i], in_delay(st_reg.timing, i));
      pins_out[i] = tap(st_reg.ohist[i], out_delay(st_reg.timing, i));
    end
  end

  assign data_valid_out  = tap(st_reg.dv_hist, st_reg.timing.data_enable_delay);
  assign irq             = |(st_reg.raw & st_reg.ena);
  assign reg_rdata       = st_reg.rdata;
  assign rx_bitclk_rise  = link_in[PIN_RX_BITCLK] & ~st_reg.rx_bitclk_prev;
  assign tx_channel_data = st_reg.tx_data;

endmodule : audio_port_irq_timing_regs

`default_nettype wire

/* bench/audio_port_irq_monitor.sv */
// assertion checker for the audio port interrupt and timing block
`timescale 1ns/10ps
`default_nettype none
module audio_port_irq_monitor
  import audio_port_irq_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic [7:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 irq,
  input wire logic [15:0]          irq_events,
  input wire logic                 rx_word_strobe,
  input wire logic                 data_valid_in,
  input wire logic                 data_valid_out,
  input wire logic [PIN_COUNT-1:0] pins_in,
  input wire logic [PIN_COUNT-1:0] pins_out,
  input wire logic [PIN_COUNT-1:0] link_in,
  input wire logic [PIN_COUNT-1:0] link_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // timing shadow; delay checks wait until every pipeline has refilled after a change
  logic [24:0] tmg_s;
  logic [2:0]  age;
  logic        settled;
  assign settled = (age == 3'h7);
  always_ff @(posedge clock) begin
    if (!rst_n || (reg_write && reg_addr == OFS_TIMING_CONTROL)) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
    if (!rst_n) tmg_s <= 25'h0000000;
    else if (reg_write && reg_addr == OFS_TIMING_CONTROL) tmg_s <= reg_wdata[24:0];
  end
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence no_cause;
    !reg_write && irq_events == 16'h0000 && !rx_word_strobe;
  endsequence
  sequence clr_all;
    reg_write && reg_addr == OFS_IRQ_CLEAR && reg_wdata[15:0] == 16'hffff ##0 irq_events == 16'h0000;
  endsequence
  sequence idle_masked_read;
    reg_read && reg_addr == OFS_IRQ_MASKED_STATUS && !irq;
  endsequence
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_masked_read: assert property (idle_masked_read |=> reg_rdata == 32'h0)
    else $error("masked status nonzero while irq low");
  a_clear_drops: assert property (clr_all ##0 !rx_word_strobe |=> !irq)
    else $error("irq still high after clearing all");
  a_irq_quiet: assert property (!irq ##0 no_cause |=> !irq)
    else $error("irq rose with no cause");
  a_irq_sticky: assert property (irq && !reg_write |=> irq)
    else $error("irq fell without a register write");
  a_dv_delay: assert property (tmg_s[23:22] == 2'h2 && settled
    |-> data_valid_out == $past(data_valid_in, 3)) else $error("data valid delay wrong");
  a_out_delay: assert property (tmg_s[15:14] == 2'h1 && settled
    |-> pins_out[OUT_TX_DATA] == $past(link_out[OUT_TX_DATA], 2)) else $error("output delay wrong");
  a_in_delay: assert property (!tmg_s[20] && tmg_s[9:8] == 2'h0 && settled
    |-> link_in[PIN_RX_DATA] == $past(pins_in[PIN_RX_DATA], 3)) else $error("input delay wrong");
  a_two_stage: assert property (tmg_s[21:20] == 2'h3 && tmg_s[9:8] == 2'h0 && tmg_s[3:2] == 2'h0
    && settled |-> link_in[PIN_RX_DATA] == $past(pins_in[PIN_RX_DATA], 5)
    && link_in[PIN_TX_WORDSEL] == $past(pins_in[PIN_TX_WORDSEL], 5)) else $error("double sync wrong");
endmodule : audio_port_irq_monitor

bind audio_port_irq_timing_regs audio_port_irq_monitor monitor (.clock, .rst_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .irq_events, .rx_word_strobe,
  .data_valid_in, .data_valid_out, .pins_in, .pins_out, .link_in, .link_out);
`default_nettype wire

/* bench/codec_model.sv */
// behavioural codec driving bit clock, word select and serial data toward the block
`timescale 1ns/10ps
`default_nettype none
module codec_model (
  input  wire logic       run,
  output logic      [4:0] pins
);
  logic [7:0] pat      = 8'h96;
  logic [3:0] cnt      = 4'h0;
  logic       bit_clk  = 1'b0;
  logic       word_sel = 1'b0;
  // half period 200 ns, always on a falling clock edge; the bit clock stands low while stopped
  initial forever begin
    #200;
    bit_clk = run & ~bit_clk;
    if (!bit_clk) pat = run ? {pat[6:0], pat[7] ^ pat[5]} : ~pat; // idle data keeps moving
    if (!bit_clk && run) cnt = cnt + 4'h1;
    if (!bit_clk && run && cnt == 4'h0) word_sel = ~word_sel;
  end
  assign pins = {bit_clk, word_sel, bit_clk, word_sel, pat[0]};
endmodule : codec_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the audio port interrupt and timing block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import audio_port_irq_pkg::*;
;
  logic                 clock = 1'b0;
  logic                 rst_n, reg_write, reg_read, irq, rx_word_strobe, rise, run;
  logic                 data_valid_in, data_valid_out, tx_slave_mode, tx_msb_right;
  logic [7:0]           reg_addr;
  logic [15:0]          irq_events;
  logic [2:0]           tx_channel_arrangement;
  logic [31:0]          reg_wdata, reg_rdata, rd_val;
  logic [PIN_COUNT-1:0] pins_in, pins_out, link_in, link_out = 5'h00;
  sample_pair_type      tx_sample, tx_channel_data;
  int                   error_cnt = 0, checked = 0;
  audio_port_irq_timing_regs dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .irq, .irq_events, .rx_word_strobe, .data_valid_in, .data_valid_out,
    .tx_slave_mode, .pins_in, .pins_out, .link_in, .link_out, .rx_bitclk_rise(rise),
    .tx_channel_arrangement, .tx_msb_right, .tx_sample, .tx_channel_data);
  codec_model codec (.run, .pins(pins_in));
  // clock, and a running count standing in for the engine's serial outputs
  always #25 clock = ~clock;
  always @(posedge clock) link_out <= link_out + 5'h01;
  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock) reg_write <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clock) reg_read <= 1'b0;
    @(negedge clock) rd_val = reg_rdata;
  endtask : rd
  task automatic fire(input logic [15:0] e, input logic s);
    @(posedge clock) {irq_events, rx_word_strobe} <= {e, s};
    @(posedge clock) {irq_events, rx_word_strobe} <= 17'h00000;
  endtask : fire
  // reset values after writes to read-only and unmapped places
  task automatic t_reset;
    logic [7:0] ofs [8] = '{OFS_IRQ_RAW_STATUS, OFS_IRQ_MASKED_STATUS, OFS_IRQ_ENABLE,
      OFS_IRQ_CLEAR, OFS_TIMING_CONTROL, OFS_RECEIVE_LENGTH, OFS_CONSTANT_VALUE, 8'h04};
    wr(OFS_IRQ_RAW_STATUS, 32'h0000ffff);
    wr(8'h04, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i]);
      chk("reset value", rd_val, 64'h0);
    end
  endtask : t_reset
  // each source except frame-complete: raised while masked, enabled, zero clear, real clear
  task automatic t_irq;
    logic [15:0] b;
    for (int n = 0; n < IRQ_COUNT; n++) begin
      b = 16'h0001 << n;
      if (n == IRQ_RX_FRAME_COMPLETE) continue;
      wr(OFS_IRQ_ENABLE, 32'h0);
      fire(b, 1'b0);
      rd(OFS_IRQ_MASKED_STATUS);
      chk("masked while disabled", {rd_val, 31'h0, irq}, 64'h0);
      wr(OFS_IRQ_ENABLE, {16'h0, b});
      rd(OFS_IRQ_ENABLE);
      chk("enable", rd_val, b);
      rd(OFS_IRQ_MASKED_STATUS);
      chk("masked and irq", {rd_val, 31'h0, irq}, {16'h0, b, 32'h1});
      wr(OFS_IRQ_CLEAR, {16'h0, ~b});
      rd(OFS_IRQ_RAW_STATUS);
      chk("raw after zero clear", rd_val, b);
      wr(OFS_IRQ_CLEAR, 32'h0000ffff);
      rd(OFS_IRQ_RAW_STATUS);
      chk("raw and irq cleared", {rd_val, 31'h0, irq}, 64'h0);
    end
  endtask : t_irq
  task automatic t_rxlen;
    wr(OFS_IRQ_ENABLE, 32'h00000200);
    wr(OFS_RECEIVE_LENGTH, 32'h00000003);
    repeat (2) fire(16'h0000, 1'b1);
    rd(OFS_IRQ_RAW_STATUS);
    chk("raw before last word", rd_val, 64'h0);
    fire(16'h0000, 1'b1);
    rd(OFS_IRQ_MASKED_STATUS);
    chk("frame complete", {rd_val, 31'h0, irq}, {32'h200, 32'h1});
    wr(OFS_IRQ_CLEAR, 32'h0000ffff);
    // an event landing in the cycle of its own clear must survive it
    fork
      wr(OFS_IRQ_CLEAR, 32'h0000ffff);
      fire(16'h0001, 1'b0);
    join
    rd(OFS_IRQ_RAW_STATUS);
    chk("event beats clear", rd_val, 64'h1);
    wr(OFS_IRQ_CLEAR, 32'h0000ffff);
  endtask : t_rxlen
  // valid delay two, data out delay one, then both double syncs on
  task automatic t_timing;
    wr(OFS_TIMING_CONTROL, 32'h00804000);
    rd(OFS_TIMING_CONTROL);
    chk("timing control", rd_val, 64'h00804000);
    @(posedge clock) data_valid_in <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock) chk("valid early", data_valid_out, 64'h0);
    @(negedge clock) chk("valid late", data_valid_out, 64'h1);
    repeat (30) @(posedge clock) data_valid_in <= ~data_valid_in;
    wr(OFS_TIMING_CONTROL, 32'h00b04000);
    repeat (40) @(posedge clock);
  endtask : t_timing
  // codec stopped, so only the inversion can lift the transmit bit clock
  task automatic t_invert;
    int rises;
    rises = 0;
    run <= 1'b0;
    wr(OFS_TIMING_CONTROL, 32'h01000000);
    tx_slave_mode <= 1'b1;
    repeat (12) @(posedge clock);
    @(negedge clock) chk("slave clocks", {link_in[PIN_TX_BITCLK], link_in[PIN_RX_BITCLK]}, 64'h2);
    @(posedge clock) tx_slave_mode <= 1'b0;
    repeat (12) @(negedge clock) rises += rise;
    @(negedge clock) chk("master clocks", {link_in[PIN_TX_BITCLK], link_in[PIN_RX_BITCLK]}, 64'h0);
    chk("rises while stopped", rises, 64'h0);
    @(posedge clock) run <= 1'b1;
    // 80 cycles span ten link clock periods exactly, so the count does not depend on phase
    repeat (10) @(posedge clock);
    rises = 0;
    repeat (80) @(negedge clock) rises += rise;
    chk("bit clock rises", rises, 64'ha);
  endtask : t_invert
  task automatic t_const;
    logic [3:0] mode [5] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'h0}; // arrangement and msb right
    logic [1:0] side [5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0}; // 1 right, 2 left constant
    wr(OFS_CONSTANT_VALUE, 32'h5a5a1234);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock) {tx_channel_arrangement, tx_msb_right} <= mode[i];
      @(posedge clock);
      @(negedge clock) chk("channel data", tx_channel_data, {side[i] == 2'h2 ? 32'h5a5a1234
        : 32'h11111111, side[i] == 2'h1 ? 32'h5a5a1234 : 32'h22222222});
    end
  endtask : t_const
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    {rst_n, reg_write, reg_read, rx_word_strobe, data_valid_in, tx_slave_mode} = 6'h00;
    {run, tx_msb_right, reg_addr, reg_wdata, irq_events} = {2'h2, 8'h00, 32'h0, 16'h0};
    tx_channel_arrangement = 3'h0;
    tx_sample = {32'h11111111, 32'h22222222};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_irq();
    t_rxlen();
    t_timing();
    t_invert();
    t_const();
    end_of_test();
  end
  // about eighteen times the expected run; a hang ends as a failure
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
